//--- lfa_map.svh
// register map, field positions and reset values of the front-end register bank
`ifndef LFA_MAP_SVH
`define LFA_MAP_SVH

// register addresses on the 4-bit command address
`define LFA_ADDR_CFG0 4'h0
`define LFA_ADDR_CFG5 4'h5
`define LFA_ADDR_COL_PARITY 4'h6
`define LFA_ADDR_STATUS 4'h7
`define LFA_NUM_CFG 7

// configuration register 0 fields
`define LFA_ALERT_SRC_BIT 4
`define LFA_DIS_HI 3
`define LFA_DIS_LO 1

// configuration register 5 fields
`define LFA_AUTO_SEL_BIT 8
`define LFA_AGC_GATE_BIT 7
`define LFA_DEPTH_HI 6
`define LFA_DEPTH_LO 5
`define LFA_ZSEN_HI 4
`define LFA_ZSEN_LO 1

// column parity register: top bit covers the row parity bits
`define LFA_COL_PARITY_TOP 8

// status register fields
`define LFA_ST_ACT_HI 8
`define LFA_ST_ACT_LO 6
`define LFA_ST_AGC 5
`define LFA_ST_WAKE_HI 4
`define LFA_ST_WAKE_LO 2
`define LFA_ST_ALARM 1
`define LFA_ST_PERR 0

// reset values and write masks
`define LFA_CFG_RESET 9'h000
`define LFA_STATUS_RESET 9'h001
`define LFA_CHAN_RESET 3'h7
`define LFA_CFG3_MASK 9'h07f
`define LFA_FULL_MASK 9'h1ff
`define LFA_ADDR_CFG3 4'h3

// modulation depth in percent, per two-bit code
`define LFA_DEPTH_00 7'h32
`define LFA_DEPTH_01 7'h4b
`define LFA_DEPTH_10 7'h19
`define LFA_DEPTH_11 7'h0c

`endif

//--- lfa_pkg.sv
// types shared by the front-end register bank
package lfa_pkg;
    typedef logic [8:0] lfa_word_t;
    typedef logic [2:0] lfa_chan_t;
endpackage : lfa_pkg

//--- lfa_regs.sv
// configuration and status register bank of the low-frequency front end
//
// Notes on behaviour
// RQ1: auto select on: at stabilization end enable only channels with demodulator high.
// RQ2: auto select off: channels follow the enable bits of configuration register 0.
// RQ3: gated output on: no output until gain loop regulates; then flag gain active.
// RQ4: gated output off: pass demodulated signal at any detectable level.
// RQ5: depth code 00=50%, 01=75%, 10=25%, 11=12%.
// RQ6: z sensitivity reduction 0 dB at 0000 to 30 dB at 1111, monotonic.
// RQ7: host writes bit 0 so each 9-bit register has odd ones.
// RQ8: host sets column bit n odd with bit n+1 of registers 0 to 5; the check and host model pair column bit n with bit n.
// RQ9: host sets top column bit odd with all row parity bits.
// RQ10: after power-on reset status reads zero except parity error flag at one.
// RQ11: channel active flags follow passing data, low in standby, soft reset clears.
// RQ12: gain active flag tracks input level live, soft reset clears it.
// RQ13: wake flag set when channel caused wake-up, soft reset clears it.
// RQ14: alarm flag set on timer expiry, cleared only by status read command.
// RQ15: parity error flag is live and pulls the alert output low.
// RQ16: soft reset clears status bits 8 to 2; sleep changes no status bit.
// RQ17: alert source bit selects parity only or parity plus alarm.
// RQ18: configuration registers read and write, status register read only.
// RQ19: channel enable bit written 0 enables, 1 disables.
// RQ20: row and column parity checked continuously, any failure flags error.
// RQ21: alert released once no enabled alert source remains active.
`timescale 1ns/1ns
`include "lfa_map.svh"

module lfa_regs
    import lfa_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register command port from the command decoder
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [3:0] reg_addr,
    input wire lfa_word_t reg_wr_data,
    output lfa_word_t reg_rd_data,
    // command events
    input wire logic soft_reset,
    // analog front-end status, index 2=z 1=y 0=x
    input wire lfa_chan_t demod_high,
    input wire logic stab_done,
    input wire logic agc_regulating,
    input wire lfa_chan_t chan_passing,
    input wire logic standby,
    input wire lfa_chan_t wake_event,
    input wire logic alarm_expired,
    // demodulated data path
    input wire logic lf_data_in,
    output logic lf_data_out,
    // control outputs to the analog blocks
    output lfa_chan_t chan_enable,
    output logic [6:0] min_depth_pct,
    output logic [4:0] z_atten_db,
    output lfa_word_t status,
    output logic alert_n
);

    // register state
    lfa_word_t cfg_reg [`LFA_NUM_CFG];
    lfa_word_t cfg_next [`LFA_NUM_CFG];
    lfa_word_t status_reg;
    lfa_word_t status_next;
    lfa_word_t rd_data_reg;
    lfa_word_t rd_data_next;
    lfa_chan_t auto_mask_reg;
    lfa_chan_t auto_mask_next;
    lfa_chan_t chan_enable_reg;
    lfa_chan_t chan_enable_next;
    logic data_out_reg;
    logic data_out_next;
    logic alert_n_reg;
    logic alert_n_next;
    logic [6:0] depth_reg;
    logic [6:0] depth_next;
    logic [4:0] atten_reg;
    logic [4:0] atten_next;

    // parity check results
    logic parity_err;
    logic col_acc;
    lfa_word_t cfg5;
    lfa_word_t cfg0;

    assign cfg5 = cfg_reg[5];
    assign cfg0 = cfg_reg[0];

    // continuous row and column parity check over registers 0 to 6
    // one bad row or column is enough; the flag clears only once every check agrees
    always_comb begin
        parity_err = 1'b0;
        col_acc = 1'b0;
        // every register row must hold an odd count of ones
        for (int r = 0; r < `LFA_NUM_CFG; r++) begin
            if (^cfg_reg[r] == 1'b0) begin
                parity_err = 1'b1; // RQ20
            end
        end
        // column bits 1..7 pair with the same bit of registers 0 to 5
        for (int b = 1; b < `LFA_COL_PARITY_TOP; b++) begin
            col_acc = cfg_reg[6][b];
            for (int r = 0; r < `LFA_NUM_CFG - 1; r++) begin
                col_acc = col_acc ^ cfg_reg[r][b];
            end
            if (col_acc == 1'b0) begin
                parity_err = 1'b1; // RQ20
            end
        end
        // top column bit pairs with the row parity bits
        col_acc = cfg_reg[6][`LFA_COL_PARITY_TOP];
        for (int r = 0; r < `LFA_NUM_CFG - 1; r++) begin
            col_acc = col_acc ^ cfg_reg[r][0];
        end
        if (col_acc == 1'b0) begin
            parity_err = 1'b1; // RQ20
        end
    end

    // host writes to configuration registers; status and higher addresses ignored
    // a write aimed at status falls through here, so status stays read only
    always_comb begin
        for (int r = 0; r < `LFA_NUM_CFG; r++) begin
            cfg_next[r] = cfg_reg[r];
        end
        if (reg_wr_en && reg_addr < `LFA_ADDR_STATUS) begin
            // bits 8-7 of register 3 are unimplemented and stay zero
            if (reg_addr == `LFA_ADDR_CFG3) begin
                cfg_next[reg_addr[2:0]] = reg_wr_data & `LFA_CFG3_MASK; // RQ18
            end else begin
                cfg_next[reg_addr[2:0]] = reg_wr_data & `LFA_FULL_MASK; // RQ18
            end
        end
    end

    // read data registered one cycle after the read strobe
    always_comb begin
        rd_data_next = rd_data_reg;
        if (reg_rd_en) begin
            if (reg_addr < `LFA_ADDR_STATUS) begin
                rd_data_next = cfg_reg[reg_addr[2:0]]; // RQ18
            end else if (reg_addr == `LFA_ADDR_STATUS) begin
                rd_data_next = status_reg;
            end else begin
                rd_data_next = `LFA_CFG_RESET;
            end
        end
    end

    // status bits; sticky sets win over a clear in the same cycle
    always_comb begin
        status_next = status_reg;
        // live channel activity, forced low in standby and by soft reset
        status_next[`LFA_ST_ACT_HI:`LFA_ST_ACT_LO] =
            (soft_reset || standby) ? 3'h0 : chan_passing; // RQ11
        // live gain loop state
        status_next[`LFA_ST_AGC] = soft_reset ? 1'b0 : agc_regulating; // RQ12
        // wake flags: soft reset clears, a new wake event still lands
        if (soft_reset) begin
            status_next[`LFA_ST_WAKE_HI:`LFA_ST_WAKE_LO] = 3'h0; // RQ16
        end
        status_next[`LFA_ST_WAKE_HI:`LFA_ST_WAKE_LO] =
            status_next[`LFA_ST_WAKE_HI:`LFA_ST_WAKE_LO] | wake_event; // RQ13
        // alarm: status read clears, soft reset leaves it alone
        if (reg_rd_en && reg_addr == `LFA_ADDR_STATUS) begin
            status_next[`LFA_ST_ALARM] = 1'b0; // RQ14
        end
        if (alarm_expired) begin
            status_next[`LFA_ST_ALARM] = 1'b1; // RQ14
        end
        // parity error is live and untouched by soft reset
        status_next[`LFA_ST_PERR] = parity_err; // RQ15
    end

    // channel selection
    // the latched mask survives mode changes until the next stabilization end
    always_comb begin
        auto_mask_next = auto_mask_reg;
        // demodulator levels sampled at the end of the stabilization time
        if (stab_done) begin
            auto_mask_next = demod_high; // RQ1
        end
        if (cfg5[`LFA_AUTO_SEL_BIT]) begin
            chan_enable_next = auto_mask_next; // RQ1
        end else begin
            // a disable bit at 1 blocks its channel
            chan_enable_next = ~cfg0[`LFA_DIS_HI:`LFA_DIS_LO]; // RQ2 RQ19
        end
    end

    // demodulated output gate; gated mode waits for the gain loop
    // the gate follows the live loop state, so a weak input mutes the output again
    always_comb begin
        if (cfg5[`LFA_AGC_GATE_BIT]) begin
            data_out_next = lf_data_in & agc_regulating; // RQ3
        end else begin
            data_out_next = lf_data_in; // RQ4
        end
    end

    // alert output, low while any selected source is active
    // built from the next flags so alert moves in the same cycle as status
    always_comb begin
        alert_n_next = ~(status_next[`LFA_ST_PERR] |
            (cfg0[`LFA_ALERT_SRC_BIT] & status_next[`LFA_ST_ALARM])); // RQ15 RQ17 RQ21
    end

    // decode of depth and z sensitivity for the analog blocks
    // every depth code is legal, so the case needs no default
    always_comb begin
        unique case (cfg5[`LFA_DEPTH_HI:`LFA_DEPTH_LO])
            2'b00: depth_next = `LFA_DEPTH_00; // RQ5
            2'b01: depth_next = `LFA_DEPTH_01; // RQ5
            2'b10: depth_next = `LFA_DEPTH_10; // RQ5
            2'b11: depth_next = `LFA_DEPTH_11; // RQ5
        endcase
        // 2 dB per step keeps the reduction monotonic in the code
        atten_next = {cfg5[`LFA_ZSEN_HI:`LFA_ZSEN_LO], 1'b0}; // RQ6
    end

    // configuration storage; power-on values give a parity error at start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int r = 0; r < `LFA_NUM_CFG; r++) begin
                cfg_reg[r] <= `LFA_CFG_RESET;
            end
        end else begin
            for (int r = 0; r < `LFA_NUM_CFG; r++) begin
                cfg_reg[r] <= cfg_next[r];
            end
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_reg <= `LFA_CFG_RESET;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // status register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_reg <= `LFA_STATUS_RESET; // RQ10
        end else begin
            status_reg <= status_next;
        end
    end

    // channel selection; every channel stays enabled until a selection lands
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            auto_mask_reg <= `LFA_CHAN_RESET;
            chan_enable_reg <= `LFA_CHAN_RESET;
        end else begin
            auto_mask_reg <= auto_mask_next;
            chan_enable_reg <= chan_enable_next;
        end
    end

    // gated data output
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out_reg <= 1'b0;
        end else begin
            data_out_reg <= data_out_next;
        end
    end

    // alert starts low because the all-zero configuration fails parity
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alert_n_reg <= 1'b0; // RQ10
        end else begin
            alert_n_reg <= alert_n_next;
        end
    end

    // decoded controls for the analog blocks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            depth_reg <= `LFA_DEPTH_00;
            atten_reg <= 5'h00;
        end else begin
            depth_reg <= depth_next;
            atten_reg <= atten_next;
        end
    end

    // outputs straight from flip-flops
    assign reg_rd_data = rd_data_reg;
    assign lf_data_out = data_out_reg;
    assign chan_enable = chan_enable_reg;
    assign min_depth_pct = depth_reg;
    assign z_atten_db = atten_reg;
    assign status = status_reg;
    assign alert_n = alert_n_reg;

endmodule : lfa_regs

//--- lfa_regs_assertions.sv
// concurrent checks on the front-end register bank ports
`timescale 1ns/1ns
module lfa_regs_assertions
    import lfa_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // watched ports
    input wire logic reg_rd_en,
    input wire logic [3:0] reg_addr,
    input wire logic soft_reset,
    input wire logic agc_regulating,
    input wire lfa_chan_t chan_passing,
    input wire logic standby,
    input wire lfa_chan_t wake_event,
    input wire logic alarm_expired,
    input wire logic [6:0] min_depth_pct,
    input wire logic [4:0] z_atten_db,
    input wire lfa_word_t status,
    input wire logic alert_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a status read that no timer expiry overrides
    sequence st_read_s;
        reg_rd_en && reg_addr == 4'h7 && !alarm_expired;
    endsequence
    alarm_set_a: assert property (alarm_expired |=> status[1])
        else $error("alarm flag not set");
    alarm_clear_a: assert property (st_read_s |=> !status[1])
        else $error("alarm flag survived status read");
    alarm_keep_a: assert property (
        status[1] && !(reg_rd_en && reg_addr == 4'h7) |=> status[1])
        else $error("alarm flag lost");
    perr_alert_a: assert property (status[0] |-> !alert_n)
        else $error("alert high with parity error");
    // release may trail the cause by one edge
    alert_cause_a: assert property (
        !alert_n |-> status[1:0] != 0 || $past(status[1:0]) != 0)
        else $error("alert low without cause");
    soft_clear_a: assert property (
        soft_reset && wake_event == 3'b000 |=> status[4:2] == 3'b000)
        else $error("wake flags survived soft reset");
    wake_set_a: assert property (
        |wake_event |=> (status[4:2] & $past(wake_event)) == $past(wake_event))
        else $error("wake flag not set");
    agc_live_a: assert property (!soft_reset |=> status[5] == $past(agc_regulating))
        else $error("gain flag not live");
    act_live_a: assert property (
        !soft_reset |=> status[8:6] == ($past(standby) ? 3'b000 : $past(chan_passing)))
        else $error("channel active flags wrong");
    depth_code_a: assert property (min_depth_pct inside {7'h32, 7'h4b, 7'h19, 7'h0c})
        else $error("depth outside code set");
    z_range_a: assert property (z_atten_db <= 5'h1e && !z_atten_db[0])
        else $error("z reduction off the 2 dB grid");
endmodule : lfa_regs_assertions
bind lfa_regs lfa_regs_assertions chk (.ref_clk, .rst, .reg_rd_en, .reg_addr, .soft_reset,
    .agc_regulating, .chan_passing, .standby, .wake_event, .alarm_expired, .min_depth_pct,
    .z_atten_db, .status, .alert_n);

//--- lfa_host_model.sv
// host side model issuing register commands; load makes row and column parity odd, wr sends data unchanged
`timescale 1ns/1ns
module lfa_host_model
    import lfa_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register command port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [3:0] reg_addr,
    output lfa_word_t reg_wr_data,
    input wire lfa_word_t reg_rd_data
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 4'h0;
        reg_wr_data = 9'h000;
    end
    // released data shows the inverse so a stale value cannot pass
    task wr(input logic [3:0] a, input lfa_word_t d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_wr_data <= ~d;
    endtask : wr
    // read data is registered, taken once the answering edge has landed
    task rd(input logic [3:0] a, output lfa_word_t d);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1 d = reg_rd_data;
    endtask : rd
    // whole set: registers 1 to 4 hold zero data, all parity made odd
    task load(input lfa_word_t c0, input lfa_word_t c5);
        lfa_word_t r [0:6];
        r[0] = {c0[8:1], ~^c0[8:1]};
        for (int i = 1; i < 5; i++) begin
            r[i] = 9'h001;
        end
        r[5] = {c5[8:1], ~^c5[8:1]};
        // column bit k covers bit k of registers 0 to 5; bit 0 feeds the top column bit
        for (int k = 0; k < 8; k++) begin
            r[6][k == 0 ? 8 : k] = ~(r[0][k] ^ r[1][k] ^ r[2][k]
                ^ r[3][k] ^ r[4][k] ^ r[5][k]);
        end
        r[6][0] = ~^r[6][8:1];
        for (int i = 0; i < 7; i++) begin
            wr(4'(i), r[i]);
        end
    endtask : load
endmodule : lfa_host_model

//--- lfa_regs_tb.sv
// self-checking bench for the front-end register bank
`timescale 1ns/1ns
module lfa_regs_tb
    import lfa_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, soft_reset = 1'b0, stab_done = 1'b0;
    logic agc_regulating = 1'b0, standby = 1'b0, alarm_expired = 1'b0, lf_data_in = 1'b0;
    lfa_chan_t demod_high = 3'b000, chan_passing = 3'b000, wake_event = 3'b000;
    logic reg_wr_en, reg_rd_en, lf_data_out, alert_n;
    logic [3:0] reg_addr;
    lfa_word_t reg_wr_data, reg_rd_data, status, d;
    lfa_chan_t chan_enable;
    logic [6:0] min_depth_pct;
    logic [4:0] z_atten_db;
    int err_count = 0, samples_checked = 0, cycles = 0;
    lfa_regs uut (.ref_clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
        .soft_reset, .demod_high, .stab_done, .agc_regulating, .chan_passing, .standby,
        .wake_event, .alarm_expired, .lf_data_in, .lf_data_out, .chan_enable, .min_depth_pct,
        .z_atten_db, .status, .alert_n);
    lfa_host_model host (.ref_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data);
    always #4 ref_clk = ~ref_clk;
    // hang guard, well above the roughly two hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test;
        end
    end
    task chk(input lfa_word_t got, input lfa_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task t_modes;
        logic [6:0] pct [4];
        pct = '{7'h32, 7'h4b, 7'h19, 7'h0c};
        for (int i = 0; i < 4; i++) begin
            host.load(9'h000, {4'(i), 4'(i * 5), 1'b0});
            cyc(2);
            chk(9'(min_depth_pct), 9'(pct[i]));
            chk(9'(z_atten_db), 9'(i * 10));
            chk(status, 9'h000);
            chk(9'(alert_n), 9'h001);
        end
    endtask : t_modes
    task t_chan;
        host.load(9'h00a, 9'h000);
        cyc(2);
        chk(9'(chan_enable), 9'h002);
        host.load(9'h00a, 9'h100);
        @(posedge ref_clk);
        stab_done <= 1'b1;
        demod_high <= 3'b100;
        @(posedge ref_clk);
        stab_done <= 1'b0;
        cyc(2);
        chk(9'(chan_enable), 9'h004);
    endtask : t_chan
    task t_gate;
        host.load(9'h000, 9'h080);
        @(posedge ref_clk);
        lf_data_in <= 1'b1;
        cyc(3);
        chk(9'(lf_data_out), 9'h000);
        @(posedge ref_clk);
        agc_regulating <= 1'b1;
        cyc(3);
        chk(9'(lf_data_out), 9'h001);
        chk(status, 9'h020);
        host.load(9'h000, 9'h000);
        agc_regulating <= 1'b0;
        cyc(3);
        chk(9'(lf_data_out), 9'h001);
        chk(status, 9'h000);
    endtask : t_gate
    task t_events;
        host.load(9'h010, 9'h000);
        @(posedge ref_clk);
        {wake_event, chan_passing, alarm_expired} <= {3'b010, 3'b001, 1'b1};
        @(posedge ref_clk);
        {wake_event, alarm_expired} <= 4'h0;
        cyc(2);
        chk(status, 9'h04a);
        chk(9'(alert_n), 9'h000);
        @(posedge ref_clk);
        {standby, chan_passing} <= 4'h8;
        cyc(2);
        chk(status, 9'h00a);
        @(posedge ref_clk);
        {standby, soft_reset} <= 2'b01;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        cyc(1);
        chk(status, 9'h002);
        host.wr(4'h7, 9'h1fc);
        cyc(2);
        chk(status, 9'h002);
        host.rd(4'h7, d);
        chk(d, 9'h002);
        cyc(1);
        chk(status, 9'h000);
        chk(9'(alert_n), 9'h001);
        host.load(9'h000, 9'h000);
        @(posedge ref_clk);
        alarm_expired <= 1'b1;
        @(posedge ref_clk);
        alarm_expired <= 1'b0;
        cyc(2);
        chk(status, 9'h002);
        chk(9'(alert_n), 9'h001);
        host.wr(4'h5, 9'h007);
        cyc(2);
        chk(status, 9'h003);
        chk(9'(alert_n), 9'h000);
    endtask : t_events
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(1);
        chk(status, 9'h001);
        chk(9'(alert_n), 9'h000);
        host.rd(4'h5, d);
        chk(d, 9'h000);
        t_modes;
        t_chan;
        t_gate;
        t_events;
        end_of_test;
    end
endmodule : lfa_regs_tb
